// ==== logic/preg_pkg.sv ====
// constants and register map for process image register access
// Behaviour
// (RULE1) control bit 7 set means the byte is a register access request
// (RULE2) control bit 6 chooses direction: one write, zero read
// (RULE3) control bits 5..0 give the register number
// (RULE4) output data word is ignored during a read
// (RULE5) master places the write value in the output data word
// (RULE6) words travel high byte first in byte 1, low byte in byte 2
// (RULE7) read answer echoes the control byte unchanged as status
// (RULE8) read answer carries the addressed register contents; code answers 0x0000 except for registers 9, 31 and 32
// (RULE9) write answer echoes control byte with bit 6 cleared
// (RULE10) master must ignore the input data word after a write
// (RULE11) user registers are write protected except the code word register 31
// (RULE12) writing 0x1235 to register 31 lifts write protection
// (RULE13) any other value in register 31 restores write protection
// (RULE14) master ends configuration by writing 0x0000 to register 31
// (RULE15) new register values affect behaviour only after a restart
// (RULE16) register 9 reads firmware version as two ascii characters
// (RULE17) register 32 holds the feature word, writable when unlocked, reads back
// (RULE18) code word is cleared on every restart
// (RULE19) accepted writes go to working registers and non-volatile storage
// (RULE20) with bit 7 clear the bytes are normal output process data
// (RULE21) rejected protected writes leave contents but are still acknowledged
package preg_pkg;
	localparam int CTRL_REG_BIT = 7;
	localparam int CTRL_WRITE_BIT = 6;
	localparam int CTRL_NUM_MSB = 5;
	localparam logic [5:0] REG_FIRMWARE_VERSION = 6'h09;
	localparam logic [5:0] REG_WRITE_UNLOCK_CODE = 6'h1F;
	localparam logic [5:0] REG_FEATURE_CONFIG = 6'h20;
	localparam logic [15:0] UNLOCK_VALUE = 16'h1235;
	localparam logic [15:0] CODE_RESET = 16'h0000;
	localparam logic [15:0] FEATURE_RESET = 16'h0006;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam int NUM_REGS = 64;
	typedef enum logic [1:0] {
		ACC_NONE,
		ACC_READ,
		ACC_WRITE
	} access_t;
endpackage

// ==== logic/preg_store.sv ====
// working and non-volatile register array; feature word latched from storage on restart
`timescale 1ns/10ps
module preg_store (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic wr_en_i,
	input wire logic [5:0] wr_num_i,
	input wire logic [15:0] wr_data_i,
	input wire logic [5:0] rd_num_i,
	output logic [15:0] rd_data_o,
	output logic [15:0] active_feature_o
);
	import preg_pkg::*;
	// non-volatile copy; survives reset since it has no reset branch
	logic [15:0] nv_mem [0:NUM_REGS-1];
	logic [15:0] ram_mem [0:NUM_REGS-1];
	logic nv_valid;
	logic loaded;
	logic [15:0] active_feature;

	always_ff @(posedge sys_clk_i) begin
		if (wr_en_i) begin
			nv_mem[wr_num_i] <= wr_data_i; // [RULE19]
		end
	end

	// nv_valid marks a feature word ever written; not reset, like storage
	always_ff @(posedge sys_clk_i) begin
		if (wr_en_i && wr_num_i == REG_FEATURE_CONFIG) begin
			nv_valid <= 1'b1;
		end else if (nv_valid !== 1'b1) begin
			nv_valid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (wr_en_i) begin
			ram_mem[wr_num_i] <= wr_data_i; // [RULE19]
		end
	end

	// behaviour word latched once after restart, not on write
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			loaded <= 1'b0;
			active_feature <= FEATURE_RESET;
		end else if (!loaded) begin
			loaded <= 1'b1;
			active_feature <= nv_valid ? nv_mem[REG_FEATURE_CONFIG] : FEATURE_RESET; // [RULE15]
		end
	end

	// feature word reads its default until storage has ever held one
	always_comb begin
		if (rd_num_i == REG_FEATURE_CONFIG && !nv_valid) begin
			rd_data_o = FEATURE_RESET; // [RULE17]
		end else begin
			rd_data_o = ram_mem[rd_num_i]; // [RULE19]
		end
	end

	assign active_feature_o = active_feature;
endmodule // preg_store

// ==== logic/process_image_register_access.sv ====
// process image register access engine of the terminal
`timescale 1ns/10ps
module process_image_register_access (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic frame_valid_i,
	input wire logic [7:0] control_byte_i,
	input wire logic [7:0] output_data_hi_i,
	input wire logic [7:0] output_data_lo_i,
	output logic [7:0] status_byte_o,
	output logic [7:0] input_data_hi_o,
	output logic [7:0] input_data_lo_o,
	output logic answer_valid_o,
	output logic [15:0] process_output_o,
	output logic process_output_valid_o,
	output logic [15:0] active_feature_o,
	output logic unlocked_o
);
	import preg_pkg::*;
	localparam logic [15:0] FIRMWARE_ID = 16'h3042; // arbitrary value

	logic [15:0] code_word;
	logic [15:0] store_rd;
	logic [15:0] read_value;
	logic [15:0] out_word;
	logic [5:0] reg_num;
	logic [7:0] status_byte;
	logic [15:0] input_word;
	logic answer_valid;
	logic [15:0] process_output;
	logic process_output_valid;
	logic accept_write;
	logic unlocked;
	access_t access;

	function automatic logic is_user_reg(input logic [5:0] num);
		is_user_reg = (num >= REG_FEATURE_CONFIG);
	endfunction

	assign reg_num = control_byte_i[CTRL_NUM_MSB:0]; // [RULE3]
	assign out_word = {output_data_hi_i, output_data_lo_i}; // [RULE6]
	assign unlocked = (code_word == UNLOCK_VALUE); // [RULE12] [RULE13]

	always_comb begin
		if (!frame_valid_i || !control_byte_i[CTRL_REG_BIT]) begin
			access = ACC_NONE; // [RULE20]
		end else if (control_byte_i[CTRL_WRITE_BIT]) begin
			access = ACC_WRITE; // [RULE1] [RULE2]
		end else begin
			access = ACC_READ;
		end
	end

	// protected writes are dropped but still acknowledged
	assign accept_write = (access == ACC_WRITE) && is_user_reg(reg_num) && unlocked; // [RULE11] [RULE21]

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			code_word <= CODE_RESET; // [RULE18]
		end else if (access == ACC_WRITE && reg_num == REG_WRITE_UNLOCK_CODE) begin
			code_word <= out_word; // [RULE11] [RULE12] [RULE13]
		end
	end

	preg_store u_store (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.wr_en_i(accept_write), // [RULE17] [RULE19]
		.wr_num_i(reg_num),
		.wr_data_i(out_word),
		.rd_num_i(reg_num),
		.rd_data_o(store_rd),
		.active_feature_o(active_feature_o)
	);

	// feature word reads back through the store so it survives a restart
	always_comb begin
		case (reg_num)
			REG_FIRMWARE_VERSION: read_value = FIRMWARE_ID; // [RULE16]
			REG_WRITE_UNLOCK_CODE: read_value = code_word;
			REG_FEATURE_CONFIG: read_value = store_rd; // [RULE17] [RULE19]
			default: read_value = WORD_RESET;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_byte <= BYTE_RESET;
			input_word <= WORD_RESET;
			answer_valid <= 1'b0;
		end else begin
			answer_valid <= (access != ACC_NONE);
			case (access)
				ACC_READ: begin
					status_byte <= control_byte_i; // [RULE7]
					input_word <= read_value; // [RULE8] [RULE4]
				end
				ACC_WRITE: begin
					status_byte <= control_byte_i & ~(8'h01 << CTRL_WRITE_BIT); // [RULE9]
					input_word <= WORD_RESET; // [RULE10]
				end
				default: begin
					status_byte <= BYTE_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			process_output <= WORD_RESET;
			process_output_valid <= 1'b0;
		end else begin
			process_output_valid <= frame_valid_i && !control_byte_i[CTRL_REG_BIT];
			if (frame_valid_i && !control_byte_i[CTRL_REG_BIT]) begin
				process_output <= out_word; // [RULE20]
			end
		end
	end

	assign status_byte_o = status_byte;
	assign input_data_hi_o = input_word[15:8]; // [RULE6]
	assign input_data_lo_o = input_word[7:0];
	assign answer_valid_o = answer_valid;
	assign process_output_o = process_output;
	assign process_output_valid_o = process_output_valid;
	assign unlocked_o = unlocked;
endmodule // process_image_register_access

// ==== testbench/pira_monitor.sv ====
// checker for process image register access
`timescale 1ns/10ps
module pira_monitor (input logic sys_clk_i, reset_n_i, frame_valid_i, answer_valid_o, unlocked_o,
	input logic process_output_valid_o, input logic [15:0] process_output_o,
	input logic [7:0] control_byte_i, output_data_hi_i, output_data_lo_i,
	input logic [7:0] status_byte_o, input_data_hi_o, input_data_lo_o);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_rd; frame_valid_i && control_byte_i[7:6] == 2'b10; endsequence
	sequence s_wr; frame_valid_i && control_byte_i[7:6] == 2'b11; endsequence
	property p_ack; frame_valid_i && control_byte_i[7] |=> answer_valid_o && !process_output_valid_o; endproperty
	a_ack: assert property (p_ack) else $error("no answer");
	property p_cause; answer_valid_o |-> $past(frame_valid_i) && $past(control_byte_i[7]); endproperty
	a_cause: assert property (p_cause) else $error("stray answer");
	property p_norm; frame_valid_i && !control_byte_i[7] |=> process_output_valid_o
		&& process_output_o == {$past(output_data_hi_i), $past(output_data_lo_i)}; endproperty
	a_norm: assert property (p_norm) else $error("bad output word");
	property p_rd; s_rd |=> status_byte_o == $past(control_byte_i); endproperty
	a_rd: assert property (p_rd) else $error("bad read status");
	property p_wr; s_wr |=> status_byte_o == ($past(control_byte_i) & 8'hBF); endproperty
	a_wr: assert property (p_wr) else $error("bad write status");
	property p_fw; s_rd ##0 control_byte_i[5:0] == 6'h09 |=> {input_data_hi_o, input_data_lo_o} == 16'h3042; endproperty
	a_fw: assert property (p_fw) else $error("bad version");
	property p_unl; s_wr ##0 control_byte_i[5:0] == 6'h1F
		|=> unlocked_o == ({$past(output_data_hi_i), $past(output_data_lo_i)} == 16'h1235); endproperty
	a_unl: assert property (p_unl) else $error("bad unlock");
	property p_code; s_rd ##0 control_byte_i[5:0] == 6'h1F
		|=> unlocked_o == ({input_data_hi_o, input_data_lo_o} == 16'h1235); endproperty
	a_code: assert property (p_code) else $error("lock mismatch");
endmodule // pira_monitor
bind process_image_register_access pira_monitor mon (.*);

// ==== testbench/pira_coupler.sv ====
// bus coupler frame driver
`timescale 1ns/10ps
module pira_coupler (input wire logic clk_i, output logic fv_o, output logic [7:0] ctl_o, hi_o, lo_o);
	initial {fv_o, ctl_o, hi_o, lo_o} = '0;
	task automatic send(input logic [7:0] k, input logic [15:0] w);
		@(posedge clk_i);
		{fv_o, ctl_o, hi_o, lo_o} <= {1'b1, k, w};
		@(posedge clk_i);
		{fv_o, ctl_o, hi_o, lo_o} <= {1'b0, ~k, ~w}; // no stale value after release
	endtask
endmodule // pira_coupler

// ==== testbench/tb_process_image_register_access.sv ====
// bench for process image register access
`timescale 1ns/10ps
module tb_process_image_register_access;
	import preg_pkg::*;
	logic sys_clk_i, reset_n_i = 1'b0, f, av, pv, un;
	logic [7:0] c, h, l, st, ih, il;
	logic [15:0] po, af, code, feat = FEATURE_RESET;
	logic [31:0] rs = 32'hB775EC57;
	int n_fail = 0, tests_run = 0;
	pira_coupler cpl (.clk_i(sys_clk_i), .fv_o(f), .ctl_o(c), .hi_o(h), .lo_o(l));
	process_image_register_access uut (.sys_clk_i, .reset_n_i, .frame_valid_i(f), .control_byte_i(c),
		.output_data_hi_i(h), .output_data_lo_i(l), .status_byte_o(st), .input_data_hi_o(ih),
		.input_data_lo_o(il), .answer_valid_o(av), .process_output_o(po), .process_output_valid_o(pv),
		.active_feature_o(af), .unlocked_o(un));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [15:0] g, e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic [7:0] k, input logic [15:0] w);
		logic [15:0] e;
		e = k[5:0] == 6'h09 ? 16'h3042 : k[5:0] == 6'h1F ? code : k[5:0] == 6'h20 ? feat : 16'h0000;
		cpl.send(k, w);
		#1;
		chk({15'h0, av}, {15'h0, k[7]});
		chk({15'h0, pv}, {15'h0, !k[7]});
		if (!k[7]) chk(po, w);
		else if (k[6]) chk({8'h00, st}, {8'h00, k & 8'hBF});
		else begin
			chk({8'h00, st}, {8'h00, k});
			chk({ih, il}, e);
		end
		if (k[7:6] == 2'b11 && k[5:0] == 6'h1F) code = w;
		if (k[7:6] == 2'b11 && k[5:0] == 6'h20 && code == UNLOCK_VALUE) feat = w;
		chk({15'h0, un}, {15'h0, code == UNLOCK_VALUE});
	endtask
	task automatic rst();
		@(posedge sys_clk_i);
		reset_n_i <= 1'b0;
		code = CODE_RESET;
		repeat (20) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		chk(af, feat);
	endtask
	task automatic finish_test();
		if (n_fail == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#200000;
		n_fail++;
		finish_test();
	end
	initial begin
		rst();
		acc(8'h89, 16'hFFFF);
		acc(8'hE0, 16'h0002);
		acc(8'hA0, 16'h0000);
		acc(8'hDF, UNLOCK_VALUE);
		acc(8'h9F, 16'h0000);
		acc(8'hE0, 16'h0002);
		acc(8'hA0, 16'h0000);
		chk(af, FEATURE_RESET);
		acc(8'hDF, 16'h0000);
		acc(8'hE0, 16'h5A5A);
		rst();
		acc(8'h9F, 16'h0000);
		acc(8'hA0, 16'hFFFF);
		repeat (300) begin
			rs = xs(rs);
			acc(rs[8] ? 8'hDF : rs[7:0], rs[9] ? UNLOCK_VALUE : rs[31:16]);
		end
		finish_test();
	end
endmodule // tb_process_image_register_access
